//--- cbh_defs.vh
// Constants for the bus hold, interrupt and reset control block.
// Assumes it is included by bare name from the design files only.
`ifndef CBH_DEFS_VH
`define CBH_DEFS_VH

// One-hot machine states
`define CBH_ST_W        7
`define CBH_ST_T1       7'h01
`define CBH_ST_T2       7'h02
`define CBH_ST_TW       7'h04
`define CBH_ST_T3       7'h08
`define CBH_ST_HOLD     7'h10
`define CBH_ST_HALT     7'h20
`define CBH_ST_IDLE     7'h40

// Bus widths and reset values
`define CBH_AW          16
`define CBH_DW          8
`define CBH_PC_RST      16'h0000
`define CBH_PC_STEP     16'h0001
`define CBH_ADDR_RST    16'h0000
`define CBH_DATA_RST    8'h00

// Phase bit positions in the edge detector vector
`define CBH_PH_ONE      0
`define CBH_PH_TWO      1
`define CBH_PH_N        2

`endif

//--- cbh_phase_edge.v
// Rising edge detector for the two externally supplied clock phases.
// Assumes the phase inputs are synchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
`include "cbh_defs.vh"

module cbh_phase_edge (
    input  wire                  clk_sys,
    input  wire                  rst_n,
    input  wire [`CBH_PH_N-1:0]  phase_in,
    output wire [`CBH_PH_N-1:0]  phase_rise
);
    genvar g;
    generate
        for (g = 0; g < `CBH_PH_N; g = g + 1) begin : g_ph
            reg prev_q;
            // Remember last level of each phase; starts high so a phase
            // already high when reset lifts is not taken as a fresh rise
            always @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    prev_q <= 1'b1;
                end else begin
                    prev_q <= phase_in[g];
                end
            end
            assign phase_rise[g] = phase_in[g] & ~prev_q;
        end
    endgenerate
endmodule // cbh_phase_edge

`default_nettype wire

//--- cbh_bus_ctrl.v
// Control-pin logic of an 8-bit processor bus: machine cycle states, wait,
// write strobe, bus handover, interrupt enable and reset of the program counter.
// Assumes the core presents the next machine cycle on its cyc_* inputs.
`timescale 1ns/1ps
`default_nettype none
`include "cbh_defs.vh"

module cbh_bus_ctrl (
    input  wire                  clk_sys,
    input  wire                  rst_n,
    input  wire                  phase_one_clock,
    input  wire                  phase_two_clock,
    input  wire                  ready,
    input  wire                  bus_yield_request,
    input  wire                  irq_request,
    input  wire [`CBH_DW-1:0]    data_in,
    output wire [`CBH_AW-1:0]    addr_out,
    output wire                  addr_oe_n,
    output wire [`CBH_DW-1:0]    data_out,
    output wire                  data_oe_n,
    output wire                  cycle_sync,
    output wire                  bus_input_enable,
    output wire                  wait_ack,
    output wire                  store_strobe_n,
    output wire                  bus_release_ack,
    output wire                  irq_enable_flag,
    input  wire [`CBH_AW-1:0]    cyc_addr,
    input  wire [`CBH_DW-1:0]    cyc_status,
    input  wire [`CBH_DW-1:0]    cyc_wdata,
    input  wire                  cyc_write,
    input  wire                  cyc_last,
    input  wire                  halt_req,
    input  wire                  ei_cmd,
    input  wire                  di_cmd,
    input  wire                  pc_load,
    input  wire [`CBH_AW-1:0]    pc_load_val,
    output wire [`CBH_AW-1:0]    pc,
    output wire [`CBH_DW-1:0]    rdata,
    output wire                  cycle_done,
    output wire                  irq_taken
);
    localparam [`CBH_ST_W-1:0] ST_T1   = `CBH_ST_T1;
    localparam [`CBH_ST_W-1:0] ST_T2   = `CBH_ST_T2;
    localparam [`CBH_ST_W-1:0] ST_TW   = `CBH_ST_TW;
    localparam [`CBH_ST_W-1:0] ST_T3   = `CBH_ST_T3;
    localparam [`CBH_ST_W-1:0] ST_HOLD = `CBH_ST_HOLD;
    localparam [`CBH_ST_W-1:0] ST_HALT = `CBH_ST_HALT;
    localparam [`CBH_ST_W-1:0] ST_IDLE = `CBH_ST_IDLE;

    wire [`CBH_PH_N-1:0] ph_rise;
    wire                 ph1;
    wire                 ph2;

    reg [`CBH_ST_W-1:0]  st_q;
    reg [`CBH_AW-1:0]    addr_q;
    reg [`CBH_DW-1:0]    dout_q;
    reg [`CBH_DW-1:0]    rdata_q;
    reg [`CBH_AW-1:0]    pc_q;
    reg                  wr_q;
    reg                  last_q;
    reg                  sync_q;
    reg                  bus_input_enable_q;
    reg                  wait_q;
    reg                  strobe_n_q;
    reg                  ack_q;
    reg                  float_q;
    reg                  drive_q;
    reg                  ie_q;
    reg                  hold_pend_q;
    reg                  ret_halt_q;
    reg                  irq_pend_q;
    reg                  done_q;
    reg                  taken_q;
    reg                  irq_ok;
    wire                 hold_exit;

    // Detect the rising edges of both phases
    cbh_phase_edge u_edge (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .phase_in   ({phase_two_clock, phase_one_clock}),
        .phase_rise (ph_rise)
    );
    assign ph1 = ph_rise[`CBH_PH_ONE];
    assign ph2 = ph_rise[`CBH_PH_TWO];

    // Interrupt honoured only when enabled and bus not released
    always @* begin
        irq_ok = irq_request & ie_q & ~ack_q & ~bus_yield_request;
    end

    // Machine cycle sequencer, stepped on each phase one rising edge
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q        <= ST_IDLE;
            addr_q      <= `CBH_ADDR_RST;
            dout_q      <= `CBH_DATA_RST;
            rdata_q     <= `CBH_DATA_RST;
            wr_q        <= 1'b0;
            last_q      <= 1'b0;
            sync_q      <= 1'b0;
            bus_input_enable_q      <= 1'b0;
            wait_q      <= 1'b0;
            strobe_n_q  <= 1'b1;
            ack_q       <= 1'b0;
            hold_pend_q <= 1'b0;
            ret_halt_q  <= 1'b0;
            irq_pend_q  <= 1'b0;
            drive_q     <= 1'b0;
            done_q      <= 1'b0;
            taken_q     <= 1'b0;
        end else begin
            done_q  <= 1'b0;
            taken_q <= 1'b0;
            if (ph1) begin
                case (st_q)
                    ST_IDLE, ST_T1: begin
                        if (st_q == ST_IDLE) begin
                            // Open a cycle: address, status and sync pulse
                            st_q    <= ST_T1;
                            addr_q  <= cyc_addr;
                            dout_q  <= cyc_status;
                            wr_q    <= cyc_write;
                            last_q  <= cyc_last;
                            sync_q  <= 1'b1;
                            drive_q <= 1'b1;
                        end else begin
                            st_q    <= ST_T2;
                            sync_q  <= 1'b0;
                            dout_q  <= cyc_wdata;
                            drive_q <= wr_q;
                            bus_input_enable_q  <= ~wr_q;
                        end
                    end
                    ST_T2, ST_TW: begin
                        if (ready) begin
                            st_q        <= ST_T3;
                            wait_q      <= 1'b0;
                            bus_input_enable_q      <= 1'b0;
                            rdata_q     <= data_in;
                            strobe_n_q  <= ~wr_q;
                            hold_pend_q <= bus_yield_request;
                            ack_q       <= bus_yield_request & ~wr_q;
                        end else begin
                            st_q   <= ST_TW;
                            wait_q <= 1'b1;
                        end
                    end
                    ST_T3: begin
                        // Cycle complete; strobe and data drive end in the same clock
                        strobe_n_q <= 1'b1;
                        drive_q    <= 1'b0;
                        done_q     <= 1'b1;
                        if (hold_pend_q) begin
                            st_q       <= ST_HOLD;
                            ack_q      <= 1'b1;
                            ret_halt_q <= 1'b0;
                            irq_pend_q <= last_q & irq_ok;
                        end else if (last_q & irq_ok) begin
                            st_q       <= ST_IDLE;
                            irq_pend_q <= 1'b1;
                            taken_q    <= 1'b1;
                        end else if (last_q & halt_req) begin
                            st_q <= ST_HALT;
                        end else begin
                            st_q <= ST_IDLE;
                        end
                    end
                    ST_HOLD: begin
                        if (!bus_yield_request) begin
                            ack_q       <= 1'b0;
                            hold_pend_q <= 1'b0;
                            st_q        <= ret_halt_q ? ST_HALT : ST_IDLE;
                        end
                    end
                    ST_HALT: begin
                        if (bus_yield_request) begin
                            st_q        <= ST_HOLD;
                            ack_q       <= 1'b1;
                            hold_pend_q <= 1'b1;
                            ret_halt_q  <= 1'b1;
                        end else if (irq_ok) begin
                            st_q       <= ST_IDLE;
                            irq_pend_q <= 1'b1;
                            taken_q    <= 1'b1;
                        end
                    end
                    default: begin
                        st_q <= ST_IDLE;
                    end
                endcase
            end
            if (ph1 && st_q == ST_IDLE) begin
                irq_pend_q <= 1'b0;
            end
        end
    end

    // Hold ends on the phase one edge that finds the request withdrawn
    assign hold_exit = ph1 & (st_q == ST_HOLD) & ~bus_yield_request;

    // Buses float only on the phase two edge after the ack was raised;
    // drive returns in the same clock as the ack drops
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            float_q <= 1'b0;
        end else if (!ack_q || hold_exit) begin
            float_q <= 1'b0;
        end else if (ph2) begin
            float_q <= 1'b1;
        end
    end

    // Enable flag: accepted interrupt clear at fetch state_one wins
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ie_q <= 1'b0;
        end else if (ph1 && st_q == ST_IDLE && irq_pend_q) begin
            ie_q <= 1'b0;
        end else if (di_cmd) begin
            ie_q <= 1'b0;
        end else if (ei_cmd) begin
            ie_q <= 1'b1;
        end
    end

    // Program counter: reset here with the flag, ack, sequencer and every other register;
    // accumulator, flags and general registers live in the core unreset
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pc_q <= `CBH_PC_RST;
        end else if (pc_load) begin
            pc_q <= pc_load_val;
        end else if (done_q && !taken_q) begin
            pc_q <= pc_q + `CBH_PC_STEP;
        end
    end

    // Pin drives; output enables are low while driving
    assign addr_out         = addr_q;
    assign addr_oe_n        = float_q;
    assign data_out         = dout_q;
    assign data_oe_n        = ~drive_q | float_q;
    assign cycle_sync       = sync_q;
    assign bus_input_enable = bus_input_enable_q;
    assign wait_ack         = wait_q;
    assign store_strobe_n   = strobe_n_q;
    assign bus_release_ack  = ack_q;
    assign irq_enable_flag  = ie_q;
    assign pc               = pc_q;
    assign rdata            = rdata_q;
    assign cycle_done       = done_q;
    assign irq_taken        = taken_q;
endmodule // cbh_bus_ctrl

`default_nettype wire

//--- cbh_props.sv
// Checker of the bus control pins.
// Assumes one clock, rst_n asynchronous low.
`timescale 1ns/1ps
`default_nettype none
module cbh_props (
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        di_cmd,
    input wire logic        addr_oe_n,
    input wire logic        data_oe_n,
    input wire logic [7:0]  data_out,
    input wire logic        cycle_sync,
    input wire logic        bus_input_enable,
    input wire logic        wait_ack,
    input wire logic        store_strobe_n,
    input wire logic        bus_release_ack,
    input wire logic        bus_yield_request,
    input wire logic        irq_enable_flag,
    input wire logic [15:0] pc,
    input wire logic        irq_taken
);
    // Checks on clk_sys, quiet in reset except reset_clear_a
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    stall_ack_a: assert property (wait_ack |-> !cycle_sync && (bus_input_enable || !data_oe_n))
        else $error("wait ack outside stall");
    strobe_data_a: assert property (!store_strobe_n |-> !data_oe_n && $stable(data_out))
        else $error("data moved under strobe");
    hold_seen_a: assert property ($rose(bus_release_ack) |-> $past(bus_yield_request))
        else $error("ack without request");
    ack_first_a: assert property ($rose(bus_release_ack) |-> !addr_oe_n)
        else $error("float before ack");
    float_ack_a: assert property (addr_oe_n |-> bus_release_ack && data_oe_n)
        else $error("float without ack");
    hold_stay_a: assert property (bus_release_ack && bus_yield_request |=> bus_release_ack)
        else $error("ack dropped early");
    input_mode_a: assert property (bus_input_enable |-> data_oe_n && store_strobe_n)
        else $error("bus driven in input");
    irq_clear_a: assert property (irq_taken |-> $past(irq_enable_flag) ##[1:24] !irq_enable_flag)
        else $error("flag not cleared");
    di_clear_a: assert property (di_cmd |=> !irq_enable_flag)
        else $error("disable ignored");
    reset_clear_a: assert property (disable iff (1'b0) !rst_n |-> !bus_release_ack && !irq_enable_flag && pc == 16'h0000)
        else $error("reset values wrong");
    // Main scenarios reached
    cover property ($rose(bus_release_ack));
    cover property (irq_taken);
    cover property (wait_ack);
endmodule // cbh_props
bind cbh_bus_ctrl cbh_props u_props (.*);
`default_nettype wire

//--- cbh_far_side.sv
// Memory and clock source facing the bus.
// Assumes phases change just after clk_sys rises.
`timescale 1ns/1ps
`default_nettype none
module cbh_far_side (
    input  wire logic        clk_sys,
    input  wire logic [1:0]  waits,
    input  wire logic        cycle_sync,
    input  wire logic        bus_input_enable,
    input  wire logic [15:0] addr_out,
    output wire logic        phase_one_clock,
    output wire logic        phase_two_clock,
    output wire logic        ready,
    output wire logic [7:0]  data_in
);
    logic [1:0] ph_q = 2'h0;
    logic [1:0] cnt_q = 2'h0;
    logic [7:0] last_q = 8'h00;
    // Two phases, four clocks a period
    always @(posedge clk_sys) ph_q <= ph_q + 2'h1;
    assign phase_one_clock = (ph_q == 2'h0);
    assign phase_two_clock = (ph_q == 2'h1);
    // Ready after the set number of stall periods
    always @(posedge clk_sys) begin
        if (cycle_sync)
            cnt_q <= 2'h0;
        else if (phase_one_clock && cnt_q != 2'h3)
            cnt_q <= cnt_q + 2'h1;
    end
    assign ready = (cnt_q >= waits);
    // Drive only in input mode, else a changing value
    always @(posedge clk_sys) last_q <= data_in;
    assign data_in = bus_input_enable ? addr_out[7:0] ^ 8'h5A : ~last_q;
endmodule // cbh_far_side
`default_nettype wire

//--- cbh_bus_ctrl_tb.sv
// Testbench of cbh_bus_ctrl with its far side model.
// Assumes reset low for 8 clocks at start.
`timescale 1ns/1ps
`default_nettype none
module cbh_bus_ctrl_tb;
    logic clk_sys = 0, rst_n = 1, ready, phase_one_clock, phase_two_clock;
    logic bus_yield_request = 0, irq_request = 0, cyc_write = 0, cyc_last = 0;
    logic halt_req = 0, ei_cmd = 0, di_cmd = 0, pc_load = 0;
    logic [7:0] data_in, data_out, cyc_status = 8'hA2, cyc_wdata = 8'h00, rdata, wd, ws;
    logic [15:0] addr_out, cyc_addr = 16'h0000, pc_load_val = 16'h0000, pc, wa;
    logic addr_oe_n, data_oe_n, cycle_sync, bus_input_enable, wait_ack;
    logic store_strobe_n, bus_release_ack, irq_enable_flag, cycle_done, irq_taken;
    logic saw_wait, saw_strobe, saw_irq;
    logic [1:0] waits = 2'h0;
    int bad_count = 0, checks_done = 0, i;
    // Rows: write, waits, address, write data, read data
    logic [34:0] rows [4] = '{{3'h0, 16'h1000, 8'h00, 8'h5A}, {3'h2, 16'hC3A5, 8'h00, 8'hFF},
                              {3'h4, 16'h2001, 8'h3C, 8'h00}, {3'h5, 16'hFFFF, 8'hC5, 8'h00}};
    always #20 clk_sys = ~clk_sys;
    cbh_bus_ctrl dut (.*);
    cbh_far_side far (.*);
    // Note what each cycle showed
    always @(posedge clk_sys) begin
        if (wait_ack === 1'b1) saw_wait <= 1'b1;
        if (store_strobe_n === 1'b0) saw_strobe <= 1'b1;
        if (store_strobe_n === 1'b0) wd <= data_out;
        if (cycle_sync === 1'b1) wa <= addr_out;
        if (cycle_sync === 1'b1) ws <= data_out;
        if (irq_taken === 1'b1) saw_irq <= 1'b1;
    end
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string m);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp, input string m);
        chk_word({15'h0000, got}, {15'h0000, exp}, m);
    endtask
    task automatic wait_done;
        int n;
        n = 0;
        while (cycle_done !== 1'b1 && n < 300) begin
            @(posedge clk_sys);
            n++;
        end
        if (n >= 300) chk_bit(1'b0, 1'b1, "no cycle end");
        @(negedge clk_sys);
    endtask
    task automatic run(input logic [26:0] r);
        {cyc_write, waits, cyc_addr, cyc_wdata} = r;
        {saw_wait, saw_strobe, saw_irq} = 3'h0;
        wait_done;
    endtask
    task automatic pulse(input logic e);
        {ei_cmd, di_cmd} = {e, ~e};
        @(negedge clk_sys);
        {ei_cmd, di_cmd} = 2'h0;
        @(negedge clk_sys);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Cut a hang short
    initial begin
        #400000;
        bad_count++;
        wrap_up;
    end
    // Main sequence
    initial begin
        #1 rst_n = 0;
        repeat (8) @(negedge clk_sys);
        chk_word(pc, 16'h0000, "pc in reset");
        chk_bit(irq_enable_flag, 1'b0, "flag in reset");
        rst_n = 1;
        wait_done;
        chk_word(pc, 16'h0001, "pc after first cycle");
        for (i = 0; i < 4; i++) begin
            run(rows[i][34:8]);
            chk_word(wa, rows[i][31:16], "cycle address");
            chk_word({8'h00, ws}, 16'h00A2, "status word");
            if (!rows[i][34]) chk_word({8'h00, rdata}, {8'h00, rows[i][7:0]}, "read data");
            else chk_word({8'h00, wd}, {8'h00, rows[i][15:8]}, "write data");
            chk_bit(saw_wait, rows[i][33:32] != 2'h0, "wait ack");
            chk_bit(saw_strobe, rows[i][34], "strobe");
        end
        $display("table done");
        bus_yield_request = 1;
        run(rows[1][34:8]);
        repeat (3) @(negedge clk_sys);
        chk_bit(bus_release_ack, 1'b1, "read ack");
        chk_bit(addr_oe_n & data_oe_n, 1'b1, "float");
        repeat (8) @(negedge clk_sys);
        chk_bit(bus_release_ack | cycle_sync, 1'b1, "ack held");
        bus_yield_request = 0;
        run(rows[0][34:8]);
        chk_bit(bus_release_ack, 1'b0, "resumed");
        chk_word({8'h00, rdata}, 16'h005A, "read after hold");
        bus_yield_request = 1;
        run(rows[2][34:8]);
        chk_bit(bus_release_ack, 1'b1, "write ack");
        pulse(1'b1);
        rst_n = 0;
        @(negedge clk_sys);
        chk_bit(bus_release_ack | irq_enable_flag, 1'b0, "mid reset");
        chk_word(pc, 16'h0000, "mid reset pc");
        bus_yield_request = 0;
        repeat (8) @(negedge clk_sys);
        rst_n = 1;
        wait_done;
        $display("hold done");
        pulse(1'b1);
        chk_bit(irq_enable_flag, 1'b1, "enable");
        {irq_request, cyc_last} = 2'h3;
        run(rows[0][34:8]);
        chk_bit(saw_irq, 1'b1, "irq taken");
        wait_done;
        chk_bit(irq_enable_flag, 1'b0, "flag cleared");
        run(rows[0][34:8]);
        chk_bit(saw_irq, 1'b0, "irq ignored");
        irq_request = 0;
        pulse(1'b1);
        pulse(1'b0);
        chk_bit(irq_enable_flag, 1'b0, "disable");
        $display("irq done");
        halt_req = 1;
        run(rows[0][34:8]);
        bus_yield_request = 1;
        repeat (8) @(negedge clk_sys);
        chk_bit(bus_release_ack & addr_oe_n, 1'b1, "halt hold");
        {bus_yield_request, halt_req} = 2'h0;
        repeat (8) @(negedge clk_sys);
        chk_word({13'h0000, bus_release_ack, addr_oe_n, cycle_sync}, 16'h0000, "back in halt");
        pulse(1'b1);
        irq_request = 1;
        run(rows[0][34:8]);
        chk_bit(saw_irq, 1'b1, "irq in halt");
        chk_bit(irq_enable_flag, 1'b0, "halt flag cleared");
        irq_request = 0;
        $display("halt done");
        wrap_up;
    end
endmodule // cbh_bus_ctrl_tb
`default_nettype wire
